// ===== cbx_cfg.svh
// Constants of the bit and load/store execution unit
`ifndef CBX_CFG_SVH
`define CBX_CFG_SVH

// ==========================================================
// Register map (word index on the slave address port)
`define CBX_IDX_GPR_LAST   8'h1f
`define CBX_IDX_CMD        8'h20
`define CBX_IDX_PC         8'h21
`define CBX_IDX_EXEC       8'h22
`define CBX_IDX_FLAGS      8'h3f
`define CBX_FLAGS_RST      8'h00
`define CBX_PC_RST         16'h0000

// ==========================================================
// Command word fields
`define CBX_OP_MSB   4
`define CBX_OP_LSB   0
`define CBX_DST_MSB  9
`define CBX_DST_LSB  5
`define CBX_SRC_MSB  14
`define CBX_SRC_LSB  10
`define CBX_K_MSB    30
`define CBX_K_LSB    15

// ==========================================================
// Status flag bit positions
`define CBX_F_C 0
`define CBX_F_Z 1
`define CBX_F_N 2
`define CBX_F_V 3
`define CBX_F_S 4
`define CBX_F_H 5
`define CBX_F_T 6
`define CBX_F_I 7

// ==========================================================
// Pointer pairs (low register index) and addressing modes
`define CBX_PTR_X_LO  5'h1a
`define CBX_PTR_Y_LO  5'h1c
`define CBX_PTR_Z_LO  5'h1e
`define CBX_PSEL_X    2'h0
`define CBX_PSEL_Y    2'h1
`define CBX_MODE_POST 2'h1
`define CBX_MODE_PRE  2'h2
`define CBX_PTR_ONE   16'h0001
`define CBX_PC_ONE    16'h0001

`endif

// ===== cbx_pkg.sv
// Types of the bit and load/store execution unit
package cbx_pkg;

  // Operation codes carried in the command word
  typedef enum logic [4:0] {
    CBX_NOP,
    CBX_SET_IO_BIT_OP,
    CBX_CLEAR_IO_BIT_OP,
    CBX_SHIFT_LEFT_OP,
    CBX_SHIFT_RIGHT_OP,
    CBX_ROTATE_LEFT_CARRY_OP,
    CBX_ROTATE_RIGHT_CARRY_OP,
    CBX_ARITH_SHIFT_RIGHT_OP,
    CBX_NIBBLE_SWAP_OP,
    CBX_GENERIC_FLAG_SET_OP,
    CBX_GENERIC_FLAG_CLEAR_OP,
    CBX_BIT_TO_TRANSFER_FLAG_OP,
    CBX_TRANSFER_FLAG_TO_BIT_OP,
    CBX_GLOBAL_IRQ_ENABLE_OP,
    CBX_GLOBAL_IRQ_DISABLE_OP,
    CBX_BRANCH_NO_OVERFLOW_OP,
    CBX_BRANCH_IRQ_ON_OP,
    CBX_BRANCH_IRQ_OFF_OP,
    CBX_REG_COPY_OP,
    CBX_REG_PAIR_COPY_OP,
    CBX_IMMEDIATE_LOAD_OP,
    CBX_INDIRECT_LOAD_OP,
    CBX_DISPLACED_LOAD_OP,
    CBX_DIRECT_LOAD_OP,
    CBX_INDIRECT_STORE_OP
  } cbx_op_type;

  // Execution phase
  typedef enum logic {
    CBX_ST_IDLE,
    CBX_ST_SECOND
  } cbx_phase_type;

  // Whole state of the unit
  typedef struct packed {
    logic [31:0][7:0] gpr;       // General-purpose registers
    logic [7:0]       flags;     // Status flags
    logic [15:0]      pc;        // Program counter
    cbx_phase_type    phase;     // Execution phase
    logic [31:0]      cmd;       // Last accepted command
    logic [4:0]       dst;       // Destination of pending load
    logic             mem_re;    // Memory read strobe
    logic             mem_we;    // Memory write strobe
    logic [15:0]      mem_addr;  // Memory address
    logic [7:0]       mem_wdata; // Memory write data
    logic             io_we;     // I/O bit write strobe
    logic [5:0]       io_addr;   // I/O register address
    logic [7:0]       io_mask;   // I/O bit mask
    logic             io_val;    // I/O bit value
    logic             ptr_upd;   // Pointer update pending
    logic [4:0]       ptr_lo;    // Pointer pair to update
    logic [15:0]      ptr_new;   // Pointer value to write
    logic             rd_ack;    // Read answer ready
    logic [31:0]      rdata;     // Read answer
  } cbx_state_type;

endpackage : cbx_pkg

// ===== cbx_exec.sv
// Bit, shift, flag, branch and load/store execution unit
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "cbx_cfg.svh"

module cbx_exec
  import cbx_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Avalon-MM slave, word addressed
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Data memory
  output logic             mem_re,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  // I/O space bit write
  output logic             io_we,
  output logic [5:0]       io_addr,
  output logic [7:0]       io_mask,
  output logic             io_val
);

  // ==========================================================
  // State registers
  cbx_state_type s_r;        // Current state
  cbx_state_type s_nxt;      // Next state

  // ==========================================================
  // Outputs straight from flip-flops
  assign avs_readdata = s_r.rdata;
  assign mem_re       = s_r.mem_re;
  assign mem_we       = s_r.mem_we;
  assign mem_addr     = s_r.mem_addr;
  assign mem_wdata    = s_r.mem_wdata;
  assign io_we        = s_r.io_we;
  assign io_addr      = s_r.io_addr;
  assign io_mask      = s_r.io_mask;
  assign io_val       = s_r.io_val;

  // Busy while the second cycle runs; reads wait one cycle
  // so that the answer can come from a flip-flop
  // Trade-off: every read costs one wait state
  assign avs_waitrequest = (s_r.phase != CBX_ST_IDLE)
                         | (avs_read & ~s_r.rd_ack);

  // ==========================================================
  // Decode helpers
  logic [31:0] cmd_w;        // Incoming command word
  cbx_op_type  op_w;         // Decoded operation
  logic [4:0]  dst_w;        // Destination register
  logic [4:0]  src_w;        // Source register or selector
  logic [15:0] k_w;          // Constant operand
  logic [2:0]  bit_w;        // Bit selector
  logic [4:0]  ptr_lo_w;     // Low register of chosen pointer
  logic [1:0]  mode_w;       // Pointer update mode
  logic [15:0] ptr_w;        // Current pointer value
  logic [7:0]  rd_w;         // Destination register value
  logic        c_w;          // Current carry
  logic        take_w;       // Idle and command write

  // Fields sliced straight from the write data
  assign cmd_w  = avs_writedata;
  assign op_w   = cbx_op_type'(cmd_w[`CBX_OP_MSB:`CBX_OP_LSB]);
  assign dst_w  = cmd_w[`CBX_DST_MSB:`CBX_DST_LSB];
  assign src_w  = cmd_w[`CBX_SRC_MSB:`CBX_SRC_LSB];
  assign k_w    = cmd_w[`CBX_K_MSB:`CBX_K_LSB];
  assign bit_w  = src_w[2:0];
  assign mode_w = src_w[3:2];
  assign rd_w   = s_r.gpr[dst_w];
  assign c_w    = s_r.flags[`CBX_F_C];
  assign take_w = avs_write & (avs_address == `CBX_IDX_CMD)
                & (s_r.phase == CBX_ST_IDLE);

  // Pointer pair chosen by the selector
  always_comb begin
    if (src_w[1:0] == `CBX_PSEL_X) begin
      ptr_lo_w = `CBX_PTR_X_LO;
    end else if (src_w[1:0] == `CBX_PSEL_Y) begin
      ptr_lo_w = `CBX_PTR_Y_LO;
    end else begin
      // Selector three lands here too
      ptr_lo_w = `CBX_PTR_Z_LO;
    end
  end

  // Pointer is high:low register pair
  assign ptr_w = {s_r.gpr[ptr_lo_w + 5'h01],
                  s_r.gpr[ptr_lo_w]};

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [7:0]  res;        // Shift or rotate result
    logic        cout;       // Carry out of shift
    logic [15:0] ea;         // Effective address
    logic [15:0] step;       // Pointer after update
    res   = 8'h00;
    cout  = 1'b0;
    ea    = 16'h0000;
    step  = 16'h0000;
    // Hold all unless a branch changes it
    s_nxt = s_r;
    // Strobes last a single cycle
    s_nxt.mem_re = 1'b0;
    s_nxt.mem_we = 1'b0;
    s_nxt.io_we  = 1'b0;
    s_nxt.rd_ack = 1'b0;

    unique case (s_r.phase)
      CBX_ST_SECOND: begin
        // Finish loads and late pointer updates
        // Load data stands during the strobe
        if (s_r.mem_re) begin
          s_nxt.gpr[s_r.dst] = mem_rdata;
        end
        // Post-increment write, one edge late
        if (s_r.ptr_upd) begin
          s_nxt.gpr[s_r.ptr_lo]         = s_r.ptr_new[7:0];
          s_nxt.gpr[s_r.ptr_lo + 5'h01] = s_r.ptr_new[15:8];
          s_nxt.ptr_upd = 1'b0;
        end
        s_nxt.phase = CBX_ST_IDLE;
      end

      CBX_ST_IDLE: begin
        // Register reads answer one cycle later
        if (avs_read & ~s_r.rd_ack) begin
          s_nxt.rd_ack = 1'b1;
          if (avs_address <= `CBX_IDX_GPR_LAST) begin
            s_nxt.rdata = {24'h000000, s_r.gpr[avs_address[4:0]]};
          end else if (avs_address == `CBX_IDX_CMD) begin
            s_nxt.rdata = s_r.cmd;
          end else if (avs_address == `CBX_IDX_PC) begin
            s_nxt.rdata = {16'h0000, s_r.pc};
          end else if (avs_address == `CBX_IDX_EXEC) begin
            // Reads wait out busy, so idle
            s_nxt.rdata = 32'h00000000;
          end else if (avs_address == `CBX_IDX_FLAGS) begin
            s_nxt.rdata = {24'h000000, s_r.flags};
          end else begin
            // Unmapped reads return zero
            s_nxt.rdata = 32'h00000000;
          end
        end

        // Direct register writes from software
        // Command word is taken further down
        // Same register hit by a command: command wins
        if (avs_write) begin
          if (avs_address <= `CBX_IDX_GPR_LAST) begin
            s_nxt.gpr[avs_address[4:0]] = avs_writedata[7:0];
          end else if (avs_address == `CBX_IDX_PC) begin
            s_nxt.pc = avs_writedata[15:0];
          end else if (avs_address == `CBX_IDX_FLAGS) begin
            s_nxt.flags = avs_writedata[7:0];
          end
        end

        // Command execution
        if (take_w) begin
          s_nxt.cmd = cmd_w;
          case (op_w)
            CBX_SET_IO_BIT_OP, CBX_CLEAR_IO_BIT_OP: begin
              // Masked bit write, flags untouched
              s_nxt.io_we   = 1'b1;
              s_nxt.io_addr = k_w[5:0];
              s_nxt.io_mask = 8'h01 << bit_w;
              s_nxt.io_val  = (op_w == CBX_SET_IO_BIT_OP);
              s_nxt.phase   = CBX_ST_SECOND;
            end

            // Shifts share one flag update
            CBX_SHIFT_LEFT_OP, CBX_SHIFT_RIGHT_OP,
            CBX_ROTATE_LEFT_CARRY_OP, CBX_ROTATE_RIGHT_CARRY_OP,
            CBX_ARITH_SHIFT_RIGHT_OP: begin
              if (op_w == CBX_SHIFT_LEFT_OP) begin
                res  = {rd_w[6:0], 1'b0};
                cout = rd_w[7];
              end else if (op_w == CBX_SHIFT_RIGHT_OP) begin
                res  = {1'b0, rd_w[7:1]};
                cout = rd_w[0];
              end else if (op_w == CBX_ROTATE_LEFT_CARRY_OP) begin
                res  = {rd_w[6:0], c_w};
                cout = rd_w[7];
              end else if (op_w == CBX_ROTATE_RIGHT_CARRY_OP) begin
                res  = {c_w, rd_w[7:1]};
                cout = rd_w[0];
              end else begin
                res  = {rd_w[7], rd_w[7:1]};
                cout = rd_w[0];
              end
              s_nxt.gpr[dst_w] = res;
              // Overflow follows negative xor carry after the shift
              s_nxt.flags[`CBX_F_Z] = (res == 8'h00);
              s_nxt.flags[`CBX_F_C] = cout;
              s_nxt.flags[`CBX_F_N] = res[7];
              s_nxt.flags[`CBX_F_V] = res[7] ^ cout;
            end

            // Halves trade places
            CBX_NIBBLE_SWAP_OP: begin
              s_nxt.gpr[dst_w] = {rd_w[3:0], rd_w[7:4]};
            end

            CBX_GENERIC_FLAG_SET_OP: begin
              // Selected flag to one
              s_nxt.flags[bit_w] = 1'b1;
            end

            // Selected flag to zero
            CBX_GENERIC_FLAG_CLEAR_OP: begin
              s_nxt.flags[bit_w] = 1'b0;
            end

            // Register bit into transfer flag
            // Limitation: only r0 to r3 reachable
            CBX_BIT_TO_TRANSFER_FLAG_OP: begin
              s_nxt.flags[`CBX_F_T] =
                s_r.gpr[src_w >> 3][bit_w];
            end

            // Transfer flag into a bit
            CBX_TRANSFER_FLAG_TO_BIT_OP: begin
              s_nxt.gpr[dst_w][bit_w] = s_r.flags[`CBX_F_T];
            end

            // Interrupt enable on
            CBX_GLOBAL_IRQ_ENABLE_OP: begin
              s_nxt.flags[`CBX_F_I] = 1'b1;
            end

            // Interrupt enable off
            CBX_GLOBAL_IRQ_DISABLE_OP: begin
              s_nxt.flags[`CBX_F_I] = 1'b0;
            end

            CBX_BRANCH_NO_OVERFLOW_OP, CBX_BRANCH_IRQ_ON_OP,
            CBX_BRANCH_IRQ_OFF_OP: begin
              // Taken branch costs a second cycle
              if ((op_w == CBX_BRANCH_NO_OVERFLOW_OP
                   && !s_r.flags[`CBX_F_V])
                  || (op_w == CBX_BRANCH_IRQ_ON_OP
                   && s_r.flags[`CBX_F_I])
                  || (op_w == CBX_BRANCH_IRQ_OFF_OP
                   && !s_r.flags[`CBX_F_I])) begin
                // Seven-bit signed offset
                s_nxt.pc    = s_r.pc + {{9{k_w[6]}}, k_w[6:0]}
                            + `CBX_PC_ONE;
                s_nxt.phase = CBX_ST_SECOND;
              end else begin
                s_nxt.pc = s_r.pc + `CBX_PC_ONE;
              end
            end

            // Byte copy, flags kept
            CBX_REG_COPY_OP: begin
              s_nxt.gpr[dst_w] = s_r.gpr[src_w];
            end

            CBX_REG_PAIR_COPY_OP: begin
              // Even-aligned pairs only
              s_nxt.gpr[{dst_w[4:1], 1'b0}] = s_r.gpr[{src_w[4:1], 1'b0}];
              s_nxt.gpr[{dst_w[4:1], 1'b1}] =
                s_r.gpr[{src_w[4:1], 1'b1}];
            end

            // Constant into the register
            CBX_IMMEDIATE_LOAD_OP: begin
              s_nxt.gpr[dst_w] = k_w[7:0];
            end

            // Address now, data at next edge
            CBX_INDIRECT_LOAD_OP, CBX_DISPLACED_LOAD_OP,
            CBX_DIRECT_LOAD_OP, CBX_INDIRECT_STORE_OP: begin
              step = ptr_w;
              if (op_w == CBX_DIRECT_LOAD_OP) begin
                ea = k_w;
              end else if (op_w == CBX_DISPLACED_LOAD_OP) begin
                ea = ptr_w + {10'h000, k_w[5:0]};
              end else if (mode_w == `CBX_MODE_PRE) begin
                // Pointer drops before the access
                ea   = ptr_w - `CBX_PTR_ONE;
                step = ea;
              end else begin
                ea = ptr_w;
                if (mode_w == `CBX_MODE_POST) begin
                  step = ptr_w + `CBX_PTR_ONE;
                end
              end
              s_nxt.mem_addr = ea;
              s_nxt.dst      = dst_w;
              // Store source sits in the destination field
              if (op_w == CBX_INDIRECT_STORE_OP) begin
                s_nxt.mem_we    = 1'b1;
                s_nxt.mem_wdata = s_r.gpr[dst_w];
              end else begin
                s_nxt.mem_re = 1'b1;
              end
              // Pre-decrement lands now, post-increment next edge
              if (op_w == CBX_INDIRECT_LOAD_OP
                  || op_w == CBX_INDIRECT_STORE_OP) begin
                if (mode_w == `CBX_MODE_PRE) begin
                  // Written at the first edge
                  s_nxt.gpr[ptr_lo_w]         = step[7:0];
                  s_nxt.gpr[ptr_lo_w + 5'h01] = step[15:8];
                end else if (mode_w == `CBX_MODE_POST) begin
                  // Parked until the second cycle
                  s_nxt.ptr_upd = 1'b1;
                  s_nxt.ptr_lo  = ptr_lo_w;
                  s_nxt.ptr_new = step;
                end
              end
              s_nxt.phase = CBX_ST_SECOND;
            end

            default: begin
              // Unknown codes and no-op change nothing
            end
          endcase
        end
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Named reset values override the zero fill
      s_r       <= '0;
      s_r.flags <= `CBX_FLAGS_RST;
      s_r.pc    <= `CBX_PC_RST;
      s_r.phase <= CBX_ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : cbx_exec
`default_nettype wire

// ===== cbx_exec_monitor.sv
// Port checker of the bit and load/store execution unit
`timescale 1ns/10ps
`default_nettype none
`include "cbx_cfg.svh"
module cbx_exec_monitor
  import cbx_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        mem_re,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic [7:0]  mem_rdata,
  input wire logic        io_we,
  input wire logic [5:0]  io_addr,
  input wire logic [7:0]  io_mask,
  input wire logic        io_val
);
  // ==========================================================
  // Sequences
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Command word taken with a given operation
  sequence s_cmd(logic [4:0] op);
    avs_write && !avs_waitrequest && avs_address == `CBX_IDX_CMD
      && avs_writedata[4:0] == op;
  endsequence
  // Shift, swap, flag, bit transfer, copy and immediate-load commands, which must finish in one cycle
  sequence s_single;
    avs_write && !avs_waitrequest && avs_address == `CBX_IDX_CMD
      && avs_writedata[4:0] inside {[5'd3:5'd14], [5'd18:5'd20]};
  endsequence
  // Second cycle stalls the bus, then strobes drop
  sequence s_stall;
    avs_waitrequest ##1 !(mem_re || mem_we || io_we);
  endsequence
  // ==========================================================
  // Assertions
  a_set_io_bit: assert property (s_cmd(CBX_SET_IO_BIT_OP) |=>
    (io_we && io_val && io_addr == $past(avs_writedata[20:15])
     && io_mask == 8'h01 << $past(avs_writedata[12:10])) ##0 s_stall)
    else $error("set bit strobe wrong");
  a_clear_io_bit: assert property (s_cmd(CBX_CLEAR_IO_BIT_OP) |=>
    (io_we && !io_val && io_addr == $past(avs_writedata[20:15])) ##0 s_stall)
    else $error("clear bit strobe wrong");
  a_io_mask_onehot: assert property (io_we |-> $onehot(io_mask))
    else $error("bit mask not one-hot");
  a_load_read: assert property (s_cmd(CBX_INDIRECT_LOAD_OP) |=>
    (mem_re && !mem_we && !io_we) ##0 s_stall)
    else $error("indirect load strobe wrong");
  a_displaced_read: assert property (s_cmd(CBX_DISPLACED_LOAD_OP) |=>
    mem_re ##0 s_stall) else $error("displaced load strobe wrong");
  a_direct_addr: assert property (s_cmd(CBX_DIRECT_LOAD_OP) |=>
    mem_re && mem_addr == $past(avs_writedata[30:15]))
    else $error("direct load address wrong");
  a_store_write: assert property (s_cmd(CBX_INDIRECT_STORE_OP) |=>
    (mem_we && !mem_re) ##0 s_stall) else $error("store strobe wrong");
  a_single_cycle: assert property (s_single |=>
    !(mem_re || mem_we || io_we || (avs_waitrequest && !avs_read)))
    else $error("one-cycle command stalled");
  a_strobe_pulse: assert property ($rose(mem_re) |=> !mem_re && !mem_we)
    else $error("memory strobe too long");
endmodule : cbx_exec_monitor
`default_nettype wire

// ===== cbx_exec_tb.sv
// Self-checking bench of the bit and load/store execution unit
`timescale 1ns/10ps
`default_nettype none
`include "cbx_cfg.svh"
// Compare, count and report one value
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module cbx_exec_tb
  import cbx_pkg::*;
();
  // ==========================================================
  // Signals
  logic        core_clk      = 1'b0;
  logic        rst_n         = 1'b0;
  logic [7:0]  avs_address   = 8'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        mem_re, mem_we, io_we, io_val;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata, mem_rdata, io_mask;
  logic [5:0]  io_addr;
  logic [15:0] lg_addr = 16'h0;  // Last memory address used
  logic [7:0]  lg_data = 8'h0;   // Last store data
  logic [15:0] lg_io   = 16'h0;  // Last bit strobe: value, addr, mask
  int          bad_count = 0;
  int          n_checks  = 0;
  typedef struct {
    cbx_op_type op; logic [4:0] d, s; logic [15:0] k;
    logic [7:0] sv, dv, f, edv, ef;
  } cbx_row_type;
  typedef struct {
    cbx_op_type op; logic [7:0] f; logic [15:0] k, pc;
  } cbx_br_type;
  // Operation, regs, operand, presets, expected result and flags
  cbx_row_type rows [12] = '{
    '{CBX_SHIFT_LEFT_OP, 16, 17, 0, 0, 8'h81, 0, 8'h02, 8'h09},
    '{CBX_SHIFT_RIGHT_OP, 16, 17, 0, 0, 8'h01, 8'h10, 0, 8'h1b},
    '{CBX_ROTATE_LEFT_CARRY_OP, 16, 17, 0, 0, 8'h80, 1, 1, 8'h09},
    '{CBX_ROTATE_RIGHT_CARRY_OP, 16, 17, 0, 0, 2, 1, 8'h81, 8'h0c},
    '{CBX_ARITH_SHIFT_RIGHT_OP, 16, 17, 0, 0, 8'h85, 0, 8'hc2, 5},
    '{CBX_NIBBLE_SWAP_OP, 16, 17, 0, 0, 8'ha5, 8'hff, 8'h5a, 8'hff},
    '{CBX_IMMEDIATE_LOAD_OP, 16, 17, 16'h3c, 0, 0, 8'h55, 8'h3c, 8'h55},
    '{CBX_TRANSFER_FLAG_TO_BIT_OP, 16, 7, 0, 0, 0, 8'h40, 8'h80, 8'h40},
    '{CBX_BIT_TO_TRANSFER_FLAG_OP, 1, 11, 0, 0, 8, 0, 8, 8'h40},
    '{CBX_REG_COPY_OP, 16, 17, 0, 8'h6e, 0, 8'h33, 8'h6e, 8'h33},
    '{CBX_REG_PAIR_COPY_OP, 16, 18, 0, 8'hc7, 0, 0, 8'hc7, 0},
    '{CBX_GLOBAL_IRQ_DISABLE_OP, 16, 0, 0, 0, 8'h11, 8'hff, 8'h11, 8'h7f}};
  // Branch operation, flags, offset and resulting counter from 0x100
  cbx_br_type brs [6] = '{
    '{CBX_BRANCH_NO_OVERFLOW_OP, 0, 5, 16'h106},
    '{CBX_BRANCH_NO_OVERFLOW_OP, 8, 5, 16'h101},
    '{CBX_BRANCH_IRQ_ON_OP, 8'h80, 16'h7e, 16'h0ff},
    '{CBX_BRANCH_IRQ_ON_OP, 0, 16'h7e, 16'h101},
    '{CBX_BRANCH_IRQ_OFF_OP, 0, 16'h7e, 16'h0ff},
    '{CBX_BRANCH_IRQ_OFF_OP, 8'h80, 16'h7e, 16'h101}};
  // ==========================================================
  // Design, clock and memory stand-in
  cbx_exec u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mem_re(mem_re), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .io_we(io_we),
    .io_addr(io_addr), .io_mask(io_mask), .io_val(io_val));
  always #10 core_clk = ~core_clk;
  // Memory content is a hash of the address
  function automatic logic [7:0] mval(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : mval
  // Outside a read the line shows junk, never stale data
  always_comb mem_rdata = mem_re ? mval(mem_addr) : ~mval(mem_addr);
  // Log strobes so checks need not race the edge
  always @(posedge core_clk) begin
    if (mem_re || mem_we) lg_addr <= mem_addr;
    if (mem_we) lg_data <= mem_wdata;
    if (io_we) lg_io <= {1'b0, io_val, io_addr, io_mask};
  end
  // ==========================================================
  // Bus tasks: hold the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic chk(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(nm, e, q)
  endtask : chk
  task automatic setp(input logic [7:0] lo, input logic [15:0] v);
    wr(lo, {24'h0, v[7:0]});
    wr(lo + 8'h01, {24'h0, v[15:8]});
  endtask : setp
  task automatic chkp(input logic [7:0] lo, input logic [15:0] v);
    chk("ptr lo", lo, {24'h0, v[7:0]});
    chk("ptr hi", lo + 8'h01, {24'h0, v[15:8]});
  endtask : chkp
  // Issue a memory command and check the address it used
  task automatic mcmd(input logic [31:0] c, input logic [15:0] a);
    wr(`CBX_IDX_CMD, c);
    @(posedge core_clk);
    `CHK("mem addr", a, lg_addr)
  endtask : mcmd
  function automatic logic [31:0] cmd(cbx_op_type op, logic [4:0] d,
                                      logic [4:0] s, logic [15:0] k);
    return {1'b0, k, s, d, op};
  endfunction : cmd
  task end_sim;
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // ==========================================================
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    end_sim();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk("flags rst", `CBX_IDX_FLAGS, {24'h0, `CBX_FLAGS_RST});
    chk("pc rst", `CBX_IDX_PC, {16'h0, `CBX_PC_RST});
    wr(8'h30, 32'hffff_ffff);
    chk("unmapped", 8'h30, 32'h0);
    foreach (rows[i]) begin
      wr(`CBX_IDX_FLAGS, {24'h0, rows[i].f});
      wr({3'h0, rows[i].s}, {24'h0, rows[i].sv});
      wr({3'h0, rows[i].d}, {24'h0, rows[i].dv});
      wr(`CBX_IDX_CMD, cmd(rows[i].op, rows[i].d, rows[i].s, rows[i].k));
      chk("result", {3'h0, rows[i].d}, {24'h0, rows[i].edv});
      chk("flags", `CBX_IDX_FLAGS, {24'h0, rows[i].ef});
    end
    for (int b = 0; b < 8; b++) begin
      wr(`CBX_IDX_FLAGS, 32'h0);
      wr(`CBX_IDX_CMD, cmd(CBX_GENERIC_FLAG_SET_OP, 0, 5'(b), 0));
      chk("flag set", `CBX_IDX_FLAGS, 32'h1 << b);
      wr(`CBX_IDX_FLAGS, 32'hff);
      wr(`CBX_IDX_CMD, cmd(CBX_GENERIC_FLAG_CLEAR_OP, 0, 5'(b), 0));
      chk("flag clr", `CBX_IDX_FLAGS, 32'hff ^ (32'h1 << b));
    end
    foreach (brs[i]) begin
      wr(`CBX_IDX_FLAGS, {24'h0, brs[i].f});
      wr(`CBX_IDX_PC, 32'h100);
      wr(`CBX_IDX_CMD, cmd(brs[i].op, 0, 0, brs[i].k));
      chk("branch pc", `CBX_IDX_PC, {16'h0, brs[i].pc});
    end
    // Pointer edge cases: carry into high byte, wrap below zero
    wr(`CBX_IDX_FLAGS, 32'h5a);
    setp({3'h0, `CBX_PTR_X_LO}, 16'h12ff);
    mcmd(cmd(CBX_INDIRECT_LOAD_OP, 16, 5'h04, 0), 16'h12ff);
    chk("ld x+", 8'h10, {24'h0, mval(16'h12ff)});
    chkp({3'h0, `CBX_PTR_X_LO}, 16'h1300);
    setp({3'h0, `CBX_PTR_Z_LO}, 16'h0);
    mcmd(cmd(CBX_INDIRECT_LOAD_OP, 16, 5'h0a, 0), 16'hffff);
    chk("ld -z", 8'h10, {24'h0, mval(16'hffff)});
    chkp({3'h0, `CBX_PTR_Z_LO}, 16'hffff);
    setp({3'h0, `CBX_PTR_Y_LO}, 16'h0200);
    mcmd(cmd(CBX_DISPLACED_LOAD_OP, 16, 1, 16'h3f), 16'h023f);
    chkp({3'h0, `CBX_PTR_Y_LO}, 16'h0200);
    mcmd(cmd(CBX_INDIRECT_LOAD_OP, 16, 1, 0), 16'h0200);
    chkp({3'h0, `CBX_PTR_Y_LO}, 16'h0200);
    mcmd(cmd(CBX_DIRECT_LOAD_OP, 16, 0, 16'hbeef), 16'hbeef);
    chk("ld k", 8'h10, {24'h0, mval(16'hbeef)});
    wr(8'h05, 32'h77);
    setp({3'h0, `CBX_PTR_X_LO}, 16'h00ff);
    mcmd(cmd(CBX_INDIRECT_STORE_OP, 5, 5'h04, 0), 16'h00ff);
    `CHK("st data", 8'h77, lg_data)
    mcmd(cmd(CBX_INDIRECT_STORE_OP, 5, 5'h08, 0), 16'h00ff);
    chkp({3'h0, `CBX_PTR_X_LO}, 16'h00ff);
    wr(`CBX_IDX_CMD, cmd(CBX_SET_IO_BIT_OP, 0, 3, 16'h1d));
    @(posedge core_clk);
    `CHK("io set", 16'h5d08, lg_io)
    wr(`CBX_IDX_CMD, cmd(CBX_CLEAR_IO_BIT_OP, 0, 6, 16'h21));
    @(posedge core_clk);
    `CHK("io clr", 16'h2140, lg_io)
    chk("flags kept", `CBX_IDX_FLAGS, 32'h5a);
    wr(`CBX_IDX_CMD, cmd(CBX_GLOBAL_IRQ_ENABLE_OP, 0, 0, 0));
    chk("irq on", `CBX_IDX_FLAGS, 32'hda);
    chk("last cmd", `CBX_IDX_CMD, cmd(CBX_GLOBAL_IRQ_ENABLE_OP, 0, 0, 0));
    // Second reset in mid-run clears the flags again
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk("flags rst2", `CBX_IDX_FLAGS, {24'h0, `CBX_FLAGS_RST});
    end_sim();
  end
endmodule : cbx_exec_tb
bind cbx_exec cbx_exec_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .mem_re(mem_re), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .io_we(io_we),
  .io_addr(io_addr), .io_mask(io_mask), .io_val(io_val));
`default_nettype wire
